//--- hw/irq_edge_sync.sv
// Purpose: Synchronise external interrupt pins and report their rising edges
// Assumes: Pins are asynchronous to i_clk
// Notes:   Three flops; a level counts once stages two and three agree
`timescale 1ns/1ps
module irq_edge_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_rise
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] rise;
    } sync_state_type;

    sync_state_type st_r;
    sync_state_type st_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("irq_edge_sync needs WIDTH of at least one");
    end

    // ----------------------------------------
    // Filter and edge detect
    // ----------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = i_pin;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        // Stage one is never looked at, only stages two and three
        for (int i = 0; i < WIDTH; i++) begin
            st_nxt.rise[i] = 1'b0;
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.level[i] = st_r.s3[i];
                st_nxt.rise[i]  = st_r.s3[i] & ~st_r.level[i];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rise = st_r.rise;

endmodule

//--- hw/legacy_emul.sv
// Purpose: Legacy keyboard controller emulation inside the USB host controller
// Assumes: One clock; memory and I/O requests each last one cycle and are answered next cycle
// Notes:   Host I/O ports are trapped only while emulation is active
//
// Overview of operation
// - Enabled emulation claims ports, raises interrupts
// - Host port writes land in input byte
// - Memory access stores or returns values; edge bits clear on writing one
// - Gate A20 level checked against data byte
// - IRQ12 rising edge sets sticky bit, W1C
// - IRQ1 rising edge sets sticky bit, W1C
// - D1h sets A20 sequence, FFh clears
// - Routing bit turns keyboard IRQs into emulation
// - Output full drives IRQ1 or IRQ12
// - Character wait interrupts when output empties
// - Interrupt status bit is combinational decode only
// - Port 60h read returns byte, empties output
// - Output byte register feeds port 60h reads
// - Port 64h read returns status register
// - Reserved upper bits read as zero
// - Memory path works beside trapped port path
// - Command bit: 60h write clears, 64h sets
// - Port writes set input full, except A20
// - Port 60h read clears output full
`timescale 1ns/1ps
`include "legacy_emul_defs.svh"
module legacy_emul #(
    parameter int ADDR_W = 12
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rstn,
    input  wire legacy_emul_pkg::mem_req_type i_mem,
    output logic [31:0]                      o_mem_rdata,
    output logic                             o_mem_ack,
    input  wire legacy_emul_pkg::io_req_type  i_io,
    output logic [7:0]                       o_io_rdata,
    output logic                             o_io_claim,
    input  wire logic                        i_kbc_irq1,
    input  wire logic                        i_kbc_irq12,
    output logic                             o_irq1,
    output logic                             o_irq12,
    output logic                             o_emul_irq
);
    import legacy_emul_pkg::*;

    emul_state_type s_r;
    emul_state_type s_nxt;
    logic [1:0]     kbc_rise;
    logic           cond_now;

    if (ADDR_W != 12) begin : g_bad_addr
        $error("legacy_emul decodes a 12-bit register address only");
    end

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    irq_edge_sync #(
        .WIDTH (2)
    ) u_kbc_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_pin  ({i_kbc_irq12, i_kbc_irq1}),
        .o_rise (kbc_rise)
    );

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic emul_cond(input emul_state_type s);
        logic c;
        c = 1'b0;
        if (s.emul_active && s.status[`LE_STS_IN_READY]) begin
            c = 1'b1;
        end
        if (s.char_wait_notify && !s.status[`LE_STS_OUT_READY]) begin
            c = 1'b1;
        end
        if (s.ext_kbc_irq_route_en && (s.kbd_irq_edge_seen || s.aux_irq_edge_seen)) begin
            c = 1'b1;
        end
        return c;
    endfunction

    function automatic logic [31:0] ctl_word(input emul_state_type s, input logic cond);
        logic [31:0] w;
        w                       = `LE_RST_WORD;
        w[`LE_CTL_EMUL_ACTIVE]  = s.emul_active;
        w[`LE_CTL_EMUL_IRQ]     = cond;
        w[`LE_CTL_CHAR_WAIT]    = s.char_wait_notify;
        w[`LE_CTL_IRQ_DRIVE]    = s.legacy_irq_drive_en;
        w[`LE_CTL_EXT_ROUTE]    = s.ext_kbc_irq_route_en;
        w[`LE_CTL_A20_SEQ]      = s.a20_cmd_in_progress;
        w[`LE_CTL_KBD_EDGE]     = s.kbd_irq_edge_seen;
        w[`LE_CTL_AUX_EDGE]     = s.aux_irq_edge_seen;
        w[`LE_CTL_A20_LEVEL]    = s.gate_a20_level;
        return w;
    endfunction

    function automatic logic is_port(input logic [15:0] p, input logic [15:0] want);
        return p == want;
    endfunction

    assign cond_now = emul_cond(s_r);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic io_hit;
        logic io_data;
        logic a20_quiet;
        io_hit      = 1'b0;
        io_data     = 1'b0;
        a20_quiet   = 1'b0;
        s_nxt          = s_r;
        s_nxt.mem_ack  = 1'b0;
        s_nxt.io_claim = 1'b0;

        // Memory path: store and return; control edge bits clear when written with one
        // direct register access
        if (i_mem.valid) begin
            s_nxt.mem_ack   = 1'b1;
            s_nxt.mem_rdata = `LE_RST_WORD;
            if (!i_mem.write) begin
                unique case (i_mem.addr)
                    `LE_OFS_CONTROL: s_nxt.mem_rdata = ctl_word(s_r, cond_now);
                    `LE_OFS_INPUT:   s_nxt.mem_rdata = {24'h00_0000, s_r.captured_host_byte};
                    `LE_OFS_OUTPUT:  s_nxt.mem_rdata = {24'h00_0000, s_r.byte_for_host};
                    `LE_OFS_STATUS:  s_nxt.mem_rdata = {24'h00_0000, s_r.status};
                    default:         s_nxt.mem_rdata = `LE_RST_WORD;
                endcase
            end else begin
                unique case (i_mem.addr)
                    `LE_OFS_CONTROL: begin
                        s_nxt.emul_active          = i_mem.wdata[`LE_CTL_EMUL_ACTIVE];
                        s_nxt.char_wait_notify     = i_mem.wdata[`LE_CTL_CHAR_WAIT];
                        s_nxt.legacy_irq_drive_en  = i_mem.wdata[`LE_CTL_IRQ_DRIVE];
                        s_nxt.ext_kbc_irq_route_en = i_mem.wdata[`LE_CTL_EXT_ROUTE];
                        s_nxt.a20_cmd_in_progress  = i_mem.wdata[`LE_CTL_A20_SEQ];
                        s_nxt.gate_a20_level       = i_mem.wdata[`LE_CTL_A20_LEVEL];
                        if (i_mem.wdata[`LE_CTL_KBD_EDGE]) begin
                            s_nxt.kbd_irq_edge_seen = 1'b0;
                        end
                        if (i_mem.wdata[`LE_CTL_AUX_EDGE]) begin
                            s_nxt.aux_irq_edge_seen = 1'b0;
                        end
                    end
                    `LE_OFS_INPUT:   s_nxt.captured_host_byte = i_mem.wdata[7:0];
                    `LE_OFS_OUTPUT:  s_nxt.byte_for_host      = i_mem.wdata[7:0];
                    `LE_OFS_STATUS:  s_nxt.status             = i_mem.wdata[7:0];
                    default: begin
                    end
                endcase
            end
        end

        // Edges are applied after the clear so a same-cycle event wins
        // IRQ1 and IRQ12 edges set
        if (kbc_rise[0]) begin
            s_nxt.kbd_irq_edge_seen = 1'b1;
        end
        if (kbc_rise[1]) begin
            s_nxt.aux_irq_edge_seen = 1'b1;
        end

        // Trapped host port path; applied last so hardware updates beat a racing store
        io_data = is_port(i_io.port, `LE_PORT_DATA);
        io_hit  = i_io.valid && s_r.emul_active && (io_data || is_port(i_io.port, `LE_PORT_CMD));
        if (io_hit) begin
            s_nxt.io_claim = 1'b1;
            if (i_io.write) begin
                s_nxt.captured_host_byte = i_io.wdata;
                s_nxt.status[`LE_STS_CMD] = !io_data;
                if (io_data) begin
                    if (s_r.a20_cmd_in_progress
                        && (i_io.wdata[`LE_A20_DATA_BIT] == s_r.gate_a20_level)) begin
                        a20_quiet = 1'b1;
                    end
                end else begin
                    if (i_io.wdata == `LE_CMD_A20_START) begin
                        s_nxt.a20_cmd_in_progress = 1'b1;
                        a20_quiet                 = 1'b1;
                    end else if (i_io.wdata == `LE_CMD_A20_END) begin
                        s_nxt.a20_cmd_in_progress = 1'b0;
                        a20_quiet                 = s_r.a20_cmd_in_progress;
                    end
                end
                if (!a20_quiet) begin
                    s_nxt.status[`LE_STS_IN_READY] = 1'b1;
                end
            end else if (io_data) begin
                s_nxt.io_rdata = s_r.byte_for_host;
                s_nxt.status[`LE_STS_OUT_READY] = 1'b0;
            end else begin
                s_nxt.io_rdata = s_r.status;
            end
        end

        // Outputs follow the state they will sit beside
        // IRQ1 or IRQ12 drive
        s_nxt.irq1     = s_nxt.emul_active && s_nxt.legacy_irq_drive_en
                         && s_nxt.status[`LE_STS_OUT_READY] && !s_nxt.status[`LE_STS_OUT_AUX];
        s_nxt.irq12    = s_nxt.emul_active && s_nxt.legacy_irq_drive_en
                         && s_nxt.status[`LE_STS_OUT_READY] && s_nxt.status[`LE_STS_OUT_AUX];
        s_nxt.emul_irq = emul_cond(s_nxt);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_mem_rdata = s_r.mem_rdata;
    assign o_mem_ack   = s_r.mem_ack;
    assign o_io_rdata  = s_r.io_rdata;
    assign o_io_claim  = s_r.io_claim;
    assign o_irq1      = s_r.irq1;
    assign o_irq12     = s_r.irq12;
    assign o_emul_irq  = s_r.emul_irq;

endmodule

//--- hw/legacy_emul_defs.svh
// Purpose: Offsets, field positions, reset values and codes for the legacy keyboard emulation block
// Assumes: 12-bit operational register address, 16-bit host I/O port address
// Notes:   Definitions only
`ifndef LEGACY_EMUL_DEFS_SVH
`define LEGACY_EMUL_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LE_OFS_CONTROL     12'h100
`define LE_OFS_INPUT       12'h104
`define LE_OFS_OUTPUT      12'h108
`define LE_OFS_STATUS      12'h10C

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define LE_CTL_EMUL_ACTIVE 0
`define LE_CTL_EMUL_IRQ    1
`define LE_CTL_CHAR_WAIT   2
`define LE_CTL_IRQ_DRIVE   3
`define LE_CTL_EXT_ROUTE   4
`define LE_CTL_A20_SEQ     5
`define LE_CTL_KBD_EDGE    6
`define LE_CTL_AUX_EDGE    7
`define LE_CTL_A20_LEVEL   8

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define LE_STS_OUT_READY   0
`define LE_STS_IN_READY    1
`define LE_STS_CMD         3
`define LE_STS_OUT_AUX     5

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define LE_RST_BYTE        8'h00
`define LE_RST_WORD        32'h0000_0000
`define LE_PORT_DATA       16'h0060
`define LE_PORT_CMD        16'h0064
`define LE_CMD_A20_START   8'hD1
`define LE_CMD_A20_END     8'hFF
`define LE_A20_DATA_BIT    1

`endif

//--- hw/legacy_emul_pkg.sv
// Purpose: Types shared by the legacy keyboard emulation block
// Assumes: Constants live in legacy_emul_defs.svh
// Notes:   Request structs carry one-cycle requests
package legacy_emul_pkg;

    // ----------------------------------------
    // Request carriers
    // ----------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } mem_req_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] port;
        logic [7:0]  wdata;
    } io_req_type;

    // ----------------------------------------
    // Block state
    // ----------------------------------------
    typedef struct packed {
        logic        emul_active;
        logic        char_wait_notify;
        logic        legacy_irq_drive_en;
        logic        ext_kbc_irq_route_en;
        logic        a20_cmd_in_progress;
        logic        kbd_irq_edge_seen;
        logic        aux_irq_edge_seen;
        logic        gate_a20_level;
        logic [7:0]  captured_host_byte;
        logic [7:0]  byte_for_host;
        logic [7:0]  status;
        logic [31:0] mem_rdata;
        logic        mem_ack;
        logic [7:0]  io_rdata;
        logic        io_claim;
        logic        irq1;
        logic        irq12;
        logic        emul_irq;
    } emul_state_type;

endpackage

//--- test/host_io_model.sv
// Purpose: Host processor issuing legacy port cycles
// Assumes: One-cycle request, no wait states
// Notes:   Idle fields carry inverted data so nothing leans on stale values
`timescale 1ns/1ps
module host_io_model (
    input  wire logic                   i_clk,
    output legacy_emul_pkg::io_req_type o_io
);
    import legacy_emul_pkg::*;
    initial o_io = '0;
    task automatic io_cycle(input logic wr, input logic [15:0] port, input logic [7:0] data);
        @(posedge i_clk);
        o_io <= {1'b1, wr, port, data};
        @(posedge i_clk);
        o_io <= {1'b0, ~wr, ~port, ~data};
    endtask
endmodule

//--- test/legacy_emul_monitor.sv
// Purpose: Port-level checks for legacy_emul
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every legacy_emul instance
`timescale 1ns/1ps
module legacy_emul_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic                         i_clk,
    input wire logic                         i_rstn,
    input wire legacy_emul_pkg::mem_req_type i_mem,
    input wire logic [31:0]                  o_mem_rdata,
    input wire logic                         o_mem_ack,
    input wire legacy_emul_pkg::io_req_type  i_io,
    input wire logic [7:0]                   o_io_rdata,
    input wire logic                         o_io_claim,
    input wire logic                         i_kbc_irq1,
    input wire logic                         i_kbc_irq12,
    input wire logic                         o_irq1,
    input wire logic                         o_irq12,
    input wire logic                         o_emul_irq
);
    import legacy_emul_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic trap_port;
    logic mapped;
    logic mem_wr;
    assign trap_port = (i_io.port == 16'h0060) || (i_io.port == 16'h0064);
    assign mapped    = i_mem.addr inside {12'h100, 12'h104, 12'h108, 12'h10C};
    assign mem_wr    = i_mem.valid && i_mem.write;
    sequence s_rd60;
        i_io.valid && !i_io.write && (i_io.port == 16'h0060);
    endsequence
    sequence s_wr64;
        i_io.valid && i_io.write && (i_io.port == 16'h0064) && !(i_io.wdata inside {8'hD1, 8'hFF});
    endsequence
    a_mem_ack_next: assert property (i_mem.valid |=> o_mem_ack) else $error("mem ack missing");
    a_ack_has_req: assert property (o_mem_ack |-> $past(i_mem.valid)) else $error("stray mem ack");
    a_unmapped_zero: assert property (i_mem.valid && !i_mem.write && !mapped |=> o_mem_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_rsvd_zero: assert property (o_mem_ack |-> o_mem_rdata[31:9] == 23'h0)
        else $error("upper bits set");
    a_claim_cause: assert property (o_io_claim |-> $past(i_io.valid) && $past(trap_port))
        else $error("claim without trapped request");
    a_other_port: assert property (i_io.valid && !trap_port |=> !o_io_claim)
        else $error("foreign port claimed");
    a_irq_excl: assert property (!(o_irq1 && o_irq12)) else $error("both irq lines high");
    a_irq_rise_cause: assert property ($rose(o_irq1) |-> $past(mem_wr) || $past(mem_wr, 2))
        else $error("irq1 rose without register write");
    a_rd60_drop: assert property (s_rd60 ##1 o_io_claim |-> !o_irq1 && !o_irq12)
        else $error("irq held after data read");
    a_wr64_emul: assert property (s_wr64 ##1 o_io_claim |-> o_emul_irq)
        else $error("command write gave no emulation irq");
endmodule
bind legacy_emul legacy_emul_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_mem(i_mem), .o_mem_rdata(o_mem_rdata), .o_mem_ack(o_mem_ack),
    .i_io(i_io), .o_io_rdata(o_io_rdata), .o_io_claim(o_io_claim), .i_kbc_irq1(i_kbc_irq1),
    .i_kbc_irq12(i_kbc_irq12), .o_irq1(o_irq1), .o_irq12(o_irq12), .o_emul_irq(o_emul_irq));

//--- test/testbench.sv
// Purpose: Self-checking bench for legacy_emul
// Assumes: Registered answers one cycle after each request
// Notes:   Drivers queue expectations, a negedge watcher compares
`timescale 1ns/1ps
module testbench;
    import legacy_emul_pkg::*;
    logic        i_clk, i_rstn, pin1, pin12, mem_ack, io_claim, irq1, irq12, emul_irq;
    mem_req_type mem;
    io_req_type  io;
    logic [31:0] mem_rdata;
    logic [7:0]  io_rdata, b, d, c;
    logic [31:0] mq[$];
    logic [8:0]  iq[$];
    logic [8:0]  ie;
    int          n_fail = 0;
    int          checked = 0;
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    legacy_emul dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_mem(mem), .o_mem_rdata(mem_rdata), .o_mem_ack(mem_ack),
        .i_io(io), .o_io_rdata(io_rdata), .o_io_claim(io_claim), .i_kbc_irq1(pin1), .i_kbc_irq12(pin12),
        .o_irq1(irq1), .o_irq12(irq12), .o_emul_irq(emul_irq));
    host_io_model host (.i_clk(i_clk), .o_io(io));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic mop(input logic wr, input logic [11:0] a, input logic [31:0] v);
        mq.push_back(wr ? 32'h0 : v);
        @(posedge i_clk);
        mem <= {1'b1, wr, a, wr ? v : 32'h0};
        @(posedge i_clk);
        mem <= {1'b0, ~wr, ~a, ~v};
    endtask
    task automatic iop(input logic wr, input logic [15:0] p, input logic [7:0] v, input logic claimed);
        if (claimed) iq.push_back({~wr, v});
        host.io_cycle(wr, p, v);
    endtask
    task automatic lv(input logic e1, input logic e12, input logic ee);
        // Two edges, though the levels sit one register stage behind and land by the first
        @(negedge i_clk);
        @(negedge i_clk);
        chk("irq_lines", {29'h0, e1, e12, ee}, {29'h0, irq1, irq12, emul_irq});
    endtask
    task automatic pin(input logic a, input logic x);
        @(posedge i_clk);
        pin1 <= a;
        pin12 <= x;
        repeat (8) @(posedge i_clk);
    endtask
    task automatic test_done;
        $display("Counts: %0d checked, %0d failed", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(negedge i_clk) begin
        if (mem_ack) begin
            if (mq.size() == 0) chk("mem_ack", 32'h0, 32'h1);
            else chk("mem_rdata", mq.pop_front(), mem_rdata);
        end
        if (io_claim) begin
            if (iq.size() == 0) begin
                chk("io_claim", 32'h0, 32'h1);
            end else begin
                ie = iq.pop_front();
                if (ie[8]) chk("io_rdata", {24'h0, ie[7:0]}, {24'h0, io_rdata});
            end
        end
    end
    initial begin
        repeat (2000) @(posedge i_clk);
        n_fail++;
        test_done();
    end
    initial begin
        mem = '0;
        pin1 = 1'b0;
        pin12 = 1'b0;
        i_rstn = 1'b0;
        void'($urandom(32'h9b34f5ed));
        b = 8'($urandom);
        d = 8'($urandom);
        c = 8'($urandom) & 8'h7F;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        mop(0, 12'h100, 32'h0);
        mop(0, 12'h10C, 32'h0);
        mop(0, 12'h1F0, 32'h0);
        iop(1, 16'h0060, b, 0);
        lv(0, 0, 0);
        mop(0, 12'h104, 32'h0);
        $display("Test reset done");
        mop(1, 12'h100, 32'h9);
        mop(1, 12'h108, {24'h0, b});
        mop(1, 12'h10C, 32'h1);
        lv(1, 0, 0);
        iop(1, 16'h0061, 8'h5A, 0);
        iop(0, 16'h0064, 8'h01, 1);
        iop(0, 16'h0060, b, 1);
        iop(0, 16'h0060, b, 1);
        lv(0, 0, 0);
        mop(0, 12'h10C, 32'h0);
        mop(1, 12'h10C, 32'h21);
        lv(0, 1, 0);
        $display("Test output done");
        mop(1, 12'h10C, 32'h0);
        iop(1, 16'h0060, d, 1);
        mop(0, 12'h104, {24'h0, d});
        mop(0, 12'h10C, 32'h2);
        lv(0, 0, 1);
        mop(0, 12'h100, 32'hB);
        iop(1, 16'h0064, c, 1);
        mop(0, 12'h104, {24'h0, c});
        mop(0, 12'h10C, 32'hA);
        mop(1, 12'h10C, 32'h0);
        lv(0, 0, 0);
        $display("Test capture done");
        iop(1, 16'h0064, 8'hD1, 1);
        mop(0, 12'h100, 32'h29);
        mop(0, 12'h10C, 32'h8);
        iop(1, 16'h0060, d & 8'hFD, 1);
        mop(0, 12'h10C, 32'h0);
        mop(0, 12'h104, {24'h0, d & 8'hFD});
        iop(1, 16'h0060, d | 8'h02, 1);
        mop(0, 12'h10C, 32'h2);
        iop(1, 16'h0064, 8'hFF, 1);
        mop(0, 12'h100, 32'hB);
        mop(0, 12'h10C, 32'hA);
        mop(1, 12'h10C, 32'h0);
        $display("Test gate done");
        mop(1, 12'h100, 32'hD);
        lv(0, 0, 1);
        mop(1, 12'h10C, 32'h1);
        lv(1, 0, 0);
        iop(0, 16'h0060, b, 1);
        lv(0, 0, 1);
        $display("Test pending done");
        mop(1, 12'h100, 32'h10);
        lv(0, 0, 0);
        pin(1, 0);
        lv(0, 0, 1);
        mop(0, 12'h100, 32'h52);
        pin(0, 1);
        mop(0, 12'h100, 32'hD2);
        mop(1, 12'h100, 32'h50);
        mop(0, 12'h100, 32'h92);
        mop(1, 12'h100, 32'h80);
        mop(0, 12'h100, 32'h0);
        iop(1, 16'h0064, 8'hD1, 0);
        mop(0, 12'h100, 32'h0);
        lv(0, 0, 0);
        $display("Test pins done");
        chk("queues", 32'h0, 32'(mq.size() + iq.size()));
        test_done();
    end
endmodule
